// ==== rtl/mcx_defs.vh ====
// Constants for the MAC CRC and cipher coprocessor
//
// Behaviour
// - Separate CRC per PDU type, enabled at reset
// - Transmit overwrites trailing CRC bytes when type matches
// - Receive mismatch: flag, drop frame, count
// - Bad header CRC drops frame silently
// - Generic CRC32 covers subnetwork address plus PDU
// - Generic CRC32 failure sets flag, bumps counter
// - Promotion CRC8 over first 13 header bytes
// - Beacon CRC32 uses generic algorithm, whole PDU
// - Beacon failures share generic counter and hardware
// - Encrypt loaded transmit block before it leaves
// - Headers, beacon, promotion, control packets stay clear
// - Drained transmit buffer requests refill, then encrypts
// - Current key sampled per 16-byte block, changeable between blocks
// - Full receive block decrypted, sent, buffer freed
// - Header parsed live to choose cipher use
// - Standalone mode exposes cipher through registers
// - Standalone mode turns hardware CRC off
// - 16-bit error counters, cleared only by writes or by reset
`ifndef MCX_DEFS_VH
`define MCX_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MCX_ADDR_SNA0      16'hFE62
`define MCX_SNA_BYTES      16'h0006
`define MCX_ADDR_CTRL      16'hFE70
`define MCX_ADDR_STAT      16'hFE71
`define MCX_ADDR_KEY       12'hFE8
`define MCX_ADDR_AIN       12'hFE9
`define MCX_ADDR_AOUT      12'hFEA
`define MCX_ADDR_E32_HI    16'hFEBA
`define MCX_ADDR_E32_LO    16'hFEBB
`define MCX_ADDR_E8_HI     16'hFEBC
`define MCX_ADDR_E8_LO     16'hFEBD

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define MCX_CTRL_RST       8'h01
`define MCX_CTRL_CRC_EN    0
`define MCX_CTRL_ENC_EN    1
`define MCX_CTRL_ALONE     2
`define MCX_CTRL_START     3
`define MCX_STAT_F32       0
`define MCX_STAT_F8        1
`define MCX_STAT_BUSY      2
`define MCX_STAT_DONE      3
`define MCX_HT_MSB         5
`define MCX_HT_LSB         4
`define MCX_HT_GEN         2'h0
`define MCX_HT_PRO         2'h1
`define MCX_HT_BCN         2'h2
`define MCX_POS_HCS        11'h002
`define MCX_POS_PRO        11'h00D
`define MCX_POS_CTL        11'h003
`define MCX_CTL_BIT        6
`define MCX_ENC_START      11'h009
`define MCX_TAIL           11'h004

// ----------------------------------------
// CRC and cipher constants
// ----------------------------------------
`define MCX_C8_POLY        8'h07
`define MCX_C8_INIT        8'h00
`define MCX_C32_POLY       32'h04C11DB7
`define MCX_C32_INIT       32'h00000000
`define MCX_ROUNDS         10

`endif

// ==== rtl/mcx_crc_step.v ====
// One byte of an MSB-first CRC update
module mcx_crc_step #(
	parameter             W    = 8,
	parameter [W-1:0]     POLY = 8'h07
) (
	input  wire [W-1:0]   crc_in,
	input  wire [7:0]     byte_in,
	output reg  [W-1:0]   crc_out
);
	integer k;
	reg     fb;

	always @* begin
		crc_out = crc_in;
		fb = 1'b0;
		for (k = 7; k >= 0; k = k - 1) begin
			fb = crc_out[W-1] ^ byte_in[k];
			crc_out = {crc_out[W-2:0], 1'b0} ^ (fb ? POLY : {W{1'b0}});
		end
	end
endmodule // mcx_crc_step

// ==== rtl/mcx_cipher.v ====
// Iterative 128-bit keyed block engine, one round per clock
`include "mcx_defs.vh"
module mcx_cipher #(
	parameter ROUNDS = `MCX_ROUNDS
) (
	input  wire         clk,
	input  wire         sys_rst,
	input  wire         start,
	input  wire [127:0] key,
	input  wire [127:0] din,
	output reg          busy,
	output reg          done,
	output reg  [127:0] dout
);
	reg  [127:0] rk_r;
	reg  [3:0]   cnt_r;
	wire [127:0] rk_nxt;
	wire [127:0] mix;

	// Round key rotates and absorbs the round number
	assign rk_nxt = {rk_r[119:0], rk_r[127:120]} ^ {124'h0, cnt_r};
	assign mix    = {dout[122:0], dout[127:123]} ^ {dout[63:0], dout[127:64]};

	always @(posedge clk) begin
		if (sys_rst) begin
			busy  <= 1'b0;
			done  <= 1'b0;
			rk_r  <= 128'h0;
			cnt_r <= 4'h0;
			dout  <= 128'h0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				// Key sampled here, so a later key write hits the next block only
				rk_r  <= key;
				dout  <= din ^ key;
				cnt_r <= ROUNDS[3:0];
				busy  <= 1'b1;
			end else if (busy) begin
				rk_r  <= rk_nxt;
				dout  <= mix ^ rk_nxt;
				cnt_r <= cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule // mcx_cipher

// ==== rtl/mcx_mac_coproc.v ====
// MAC coprocessor: PDU CRC insert and check, in-line and standalone cipher
//
// Our own choices: the address-and-strobe port and the address map.
`include "mcx_defs.vh"
module mcx_mac_coproc (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire [15:0] reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire        tx_in_valid,
	input  wire [7:0]  tx_in_data,
	input  wire        tx_in_first,
	input  wire [10:0] tx_len,
	output reg         tx_dma_req,
	output reg         tx_phy_valid,
	output reg  [7:0]  tx_phy_data,
	output reg         tx_phy_last,
	input  wire        rx_phy_valid,
	input  wire [7:0]  rx_phy_data,
	input  wire        rx_phy_first,
	input  wire [10:0] rx_len,
	output reg         rx_dma_valid,
	output reg  [7:0]  rx_dma_data,
	output reg         rx_dma_last,
	output reg         rx_drop
);
	localparam FILL = 2'd0;
	localparam KS   = 2'd1;
	localparam DRN  = 2'd2;
	localparam OWN_TX = 2'd0;
	localparam OWN_RX = 2'd1;
	localparam OWN_SW = 2'd2;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg  [7:0]   ctrl_r;
	reg  [47:0]  sna_r;
	reg  [127:0] key_r;
	reg  [127:0] ain_r;
	reg  [15:0]  e32_r;
	reg  [15:0]  e8_r;
	reg  [15:0]  e32_nxt;
	reg  [15:0]  e8_nxt;
	reg          f32_r;
	reg          f8_r;
	reg          adone_r;
	reg          sw_pend_r;
	reg  [7:0]   rd_val;
	wire         rx_ev32;
	wire         rx_ev8;
	wire         c_busy;
	wire         c_done;
	wire [127:0] c_dout;
	reg  [1:0]   own_r;
	wire         g_sw;

	wire [15:0] sna_off = reg_addr - `MCX_ADDR_SNA0;
	wire        sna_hit = (sna_off < `MCX_SNA_BYTES);
	wire [5:0]  sna_pos = 6'd40 - {sna_off[2:0], 3'b000};
	wire [6:0]  blk_pos = {~reg_addr[3:0], 3'b000};
	wire        wr_stat = reg_wr && (reg_addr == `MCX_ADDR_STAT);
	wire        wr_ctrl = reg_wr && (reg_addr == `MCX_ADDR_CTRL);
	// Standalone use turns off both automatic CRC and in-line cipher
	wire        alone   = ctrl_r[`MCX_CTRL_ALONE];
	wire        crc_on  = ctrl_r[`MCX_CTRL_CRC_EN] & ~alone;
	wire        enc_on  = ctrl_r[`MCX_CTRL_ENC_EN] & ~alone;

	always @* begin
		e32_nxt = e32_r;
		e8_nxt  = e8_r;
		if (reg_wr && reg_addr == `MCX_ADDR_E32_HI) e32_nxt[15:8] = reg_wdata;
		if (reg_wr && reg_addr == `MCX_ADDR_E32_LO) e32_nxt[7:0] = reg_wdata;
		if (reg_wr && reg_addr == `MCX_ADDR_E8_HI) e8_nxt[15:8] = reg_wdata;
		if (reg_wr && reg_addr == `MCX_ADDR_E8_LO) e8_nxt[7:0] = reg_wdata;
		// An increment in the cycle of a write lands on the written value
		if (rx_ev32) e32_nxt = e32_nxt + 16'h0001;
		if (rx_ev8) e8_nxt = e8_nxt + 16'h0001;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			ctrl_r    <= `MCX_CTRL_RST;
			sna_r     <= 48'h0;
			key_r     <= 128'h0;
			ain_r     <= 128'h0;
			e32_r     <= 16'h0000;
			e8_r      <= 16'h0000;
			f32_r     <= 1'b0;
			f8_r      <= 1'b0;
			adone_r   <= 1'b0;
			sw_pend_r <= 1'b0;
		end else begin
			e32_r <= e32_nxt;
			e8_r  <= e8_nxt;
			if (wr_ctrl) ctrl_r <= reg_wdata & ~(8'h01 << `MCX_CTRL_START);
			if (reg_wr && sna_hit) sna_r[sna_pos +: 8] <= reg_wdata;
			if (reg_wr && reg_addr[15:4] == `MCX_ADDR_KEY) key_r[blk_pos +: 8] <= reg_wdata;
			if (reg_wr && reg_addr[15:4] == `MCX_ADDR_AIN) ain_r[blk_pos +: 8] <= reg_wdata;
			// Sticky flags: hardware set wins over a write-one clear
			f32_r   <= (f32_r & ~(wr_stat & reg_wdata[`MCX_STAT_F32])) | rx_ev32;
			f8_r    <= (f8_r & ~(wr_stat & reg_wdata[`MCX_STAT_F8])) | rx_ev8;
			adone_r <= (adone_r & ~(wr_stat & reg_wdata[`MCX_STAT_DONE]))
				| (c_done & own_r == OWN_SW);
			if (wr_ctrl && reg_wdata[`MCX_CTRL_START] && reg_wdata[`MCX_CTRL_ALONE]) begin
				sw_pend_r <= 1'b1;
			end else if (g_sw) begin
				sw_pend_r <= 1'b0;
			end
		end
	end

	always @* begin
		rd_val = 8'h00;
		case (reg_addr)
			`MCX_ADDR_CTRL:   rd_val = ctrl_r;
			`MCX_ADDR_STAT:   rd_val = {4'h0, adone_r, c_busy | sw_pend_r, f8_r, f32_r};
			`MCX_ADDR_E32_HI: rd_val = e32_r[15:8];
			`MCX_ADDR_E32_LO: rd_val = e32_r[7:0];
			`MCX_ADDR_E8_HI:  rd_val = e8_r[15:8];
			`MCX_ADDR_E8_LO:  rd_val = e8_r[7:0];
			default: begin
				if (sna_hit) rd_val = sna_r[sna_pos +: 8];
				else if (reg_addr[15:4] == `MCX_ADDR_KEY) rd_val = key_r[blk_pos +: 8];
				else if (reg_addr[15:4] == `MCX_ADDR_AIN) rd_val = ain_r[blk_pos +: 8];
				else if (reg_addr[15:4] == `MCX_ADDR_AOUT) rd_val = c_dout[blk_pos +: 8];
			end
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) reg_rdata <= 8'h00;
		else reg_rdata <= reg_rd ? rd_val : 8'h00;
	end

	// ----------------------------------------
	// Address seed for the generic CRC32
	// ----------------------------------------
	// Pre-run over the address so frames never stall for it
	reg  [2:0]  seed_cnt_r;
	reg  [31:0] seed_r;
	wire [31:0] seed_s;
	wire [5:0]  seed_pos = 6'd40 - {seed_cnt_r, 3'b000};

	mcx_crc_step #(.W(32), .POLY(`MCX_C32_POLY)) u_seed (
		.crc_in  (seed_r),
		.byte_in (sna_r[seed_pos +: 8]),
		.crc_out (seed_s)
	);

	always @(posedge clk) begin
		if (sys_rst || (reg_wr && sna_hit)) begin
			seed_cnt_r <= 3'd0;
			seed_r     <= `MCX_C32_INIT;
		end else if (seed_cnt_r != 3'd6) begin
			seed_cnt_r <= seed_cnt_r + 3'd1;
			seed_r     <= seed_s;
		end
	end

	// ----------------------------------------
	// Shared cipher and its arbiter
	// ----------------------------------------
	reg  [1:0] tx_st_r;
	reg  [1:0] rx_st_r;
	reg        tx_iss_r;
	reg        rx_iss_r;
	reg  [6:0] tx_blk_r;
	reg  [6:0] rx_blk_r;
	// Receive first: the line cannot be paused, transmit can
	wire g_rx = (rx_st_r == KS) & ~rx_iss_r & ~c_busy;
	wire g_tx = (tx_st_r == KS) & ~tx_iss_r & ~c_busy & ~g_rx;
	assign g_sw = sw_pend_r & alone & ~c_busy & ~g_rx & ~g_tx;
	// Block number is the keystream input; the same stream undoes itself on receive
	wire [127:0] c_din = g_sw ? ain_r : {121'h0, g_rx ? rx_blk_r : tx_blk_r};

	mcx_cipher #(.ROUNDS(`MCX_ROUNDS)) u_cipher (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (g_rx | g_tx | g_sw),
		.key     (key_r),
		.din     (c_din),
		.busy    (c_busy),
		.done    (c_done),
		.dout    (c_dout)
	);

	always @(posedge clk) begin
		if (sys_rst) own_r <= OWN_TX;
		else if (g_rx) own_r <= OWN_RX;
		else if (g_tx) own_r <= OWN_TX;
		else if (g_sw) own_r <= OWN_SW;
	end

	// ----------------------------------------
	// Transmit: CRC overwrite and encryption
	// ----------------------------------------
	reg  [7:0]  tx_buf_r [0:15];
	reg  [15:0] tx_msk_r;
	reg  [4:0]  tx_cnt_r;
	reg  [3:0]  tx_rd_r;
	reg  [10:0] tx_idx_r;
	reg  [10:0] tx_len_r;
	reg  [1:0]  tx_ht_r;
	reg         tx_ctl_r;
	reg         tx_last_r;
	reg  [7:0]  tx_c8_r;
	reg  [31:0] tx_c32_r;
	reg  [7:0]  tx_b;
	reg  [7:0]  tx_c8_nxt;
	reg  [31:0] tx_c32_nxt;
	wire [7:0]  tx_s8;
	wire [31:0] tx_s32;
	integer     k;
	integer     j;

	wire        tx_acc = tx_in_valid & tx_dma_req;
	wire [10:0] tx_i   = tx_in_first ? 11'h000 : tx_idx_r;
	wire [10:0] tx_l   = tx_in_first ? tx_len : tx_len_r;
	// Type read from the first byte as it passes
	wire [1:0]  tx_h   = tx_in_first ? tx_in_data[`MCX_HT_MSB:`MCX_HT_LSB] : tx_ht_r;
	wire        tx_a8  = crc_on & (tx_h == `MCX_HT_GEN | tx_h == `MCX_HT_PRO);
	wire        tx_a32 = crc_on & (tx_h == `MCX_HT_GEN | tx_h == `MCX_HT_BCN);
	wire [10:0] tx_p8  = (tx_h == `MCX_HT_GEN) ? `MCX_POS_HCS : `MCX_POS_PRO;
	wire        tx_tl  = tx_i >= tx_l - `MCX_TAIL;
	wire [7:0]  tx_k8  = tx_in_first ? `MCX_C8_INIT : tx_c8_r;
	wire [31:0] tx_k32 = !tx_in_first ? tx_c32_r
		: (tx_h == `MCX_HT_GEN) ? seed_r : `MCX_C32_INIT;
	// Generic body and its CRC are ciphered; header, beacon, promotion, control are not
	wire        tx_me  = enc_on & (tx_h == `MCX_HT_GEN) & ~tx_ctl_r
		& (tx_i >= `MCX_ENC_START);
	wire        tx_end = (tx_cnt_r == 5'd15) | (tx_i == tx_l - 11'h001);

	mcx_crc_step #(.W(8), .POLY(`MCX_C8_POLY)) u_tx8 (
		.crc_in  (tx_k8),
		.byte_in (tx_in_data),
		.crc_out (tx_s8)
	);

	mcx_crc_step #(.W(32), .POLY(`MCX_C32_POLY)) u_tx32 (
		.crc_in  (tx_k32),
		.byte_in (tx_b),
		.crc_out (tx_s32)
	);

	always @* begin
		tx_b = tx_in_data;
		if (tx_a8 && tx_i == tx_p8) tx_b = tx_k8;
		if (tx_a32 && tx_tl) tx_b = tx_k32[31:24];
	end

	always @* begin
		tx_c8_nxt  = tx_k8;
		tx_c32_nxt = tx_k32;
		if (tx_a8 && tx_i < tx_p8) tx_c8_nxt = tx_s8;
		if (tx_a32 && tx_tl) tx_c32_nxt = {tx_k32[23:0], 8'h00};
		else if (tx_a32) tx_c32_nxt = tx_s32;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			tx_st_r <= FILL; tx_dma_req <= 1'b0; tx_phy_valid <= 1'b0;
			tx_phy_data <= 8'h00; tx_phy_last <= 1'b0; tx_msk_r <= 16'h0;
			tx_cnt_r <= 5'd0; tx_rd_r <= 4'h0; tx_idx_r <= 11'h0;
			tx_len_r <= 11'h0; tx_ht_r <= 2'h0; tx_ctl_r <= 1'b0;
			tx_last_r <= 1'b0; tx_c8_r <= 8'h00; tx_c32_r <= 32'h0;
			tx_blk_r <= 7'h0; tx_iss_r <= 1'b0;
		end else begin
			tx_phy_valid <= 1'b0;
			tx_phy_last  <= 1'b0;
			case (tx_st_r)
				FILL: begin
					tx_dma_req <= ~(tx_acc & tx_end);
					if (tx_acc) begin
						tx_buf_r[tx_cnt_r[3:0]] <= tx_b;
						tx_msk_r[tx_cnt_r[3:0]] <= tx_me;
						tx_cnt_r  <= tx_cnt_r + 5'd1;
						tx_idx_r  <= tx_i + 11'h001;
						tx_len_r  <= tx_l;
						tx_ht_r   <= tx_h;
						tx_c8_r   <= tx_c8_nxt;
						tx_c32_r  <= tx_c32_nxt;
						tx_last_r <= (tx_i == tx_l - 11'h001);
						if (tx_in_first) tx_blk_r <= 7'h0;
						if (tx_in_first) tx_ctl_r <= 1'b0;
						else if (tx_i == `MCX_POS_CTL) tx_ctl_r <= tx_in_data[`MCX_CTL_BIT];
						if (tx_end) tx_st_r <= (|tx_msk_r | tx_me) ? KS : DRN;
					end
				end
				KS: begin
					if (g_tx) tx_iss_r <= 1'b1;
					if (c_done && own_r == OWN_TX) begin
						for (k = 0; k < 16; k = k + 1) begin
							if (tx_msk_r[k]) tx_buf_r[k] <= tx_buf_r[k] ^ c_dout[(15-k)*8 +: 8];
						end
						tx_iss_r <= 1'b0;
						tx_st_r  <= DRN;
					end
				end
				DRN: begin
					tx_phy_valid <= 1'b1;
					tx_phy_data  <= tx_buf_r[tx_rd_r];
					tx_rd_r      <= tx_rd_r + 4'h1;
					if ({1'b0, tx_rd_r} == tx_cnt_r - 5'd1) begin
						tx_phy_last <= tx_last_r;
						// Buffer empty: ask the DMA for the next block
						tx_cnt_r   <= 5'd0;
						tx_rd_r    <= 4'h0;
						tx_msk_r   <= 16'h0;
						tx_blk_r   <= tx_blk_r + 7'h01;
						tx_dma_req <= 1'b1;
						tx_st_r    <= FILL;
					end
				end
				default: tx_st_r <= FILL;
			endcase
		end
	end

	// ----------------------------------------
	// Receive: decryption and CRC check
	// ----------------------------------------
	// Bytes arriving outside FILL are lost; the line rate leaves ample gap
	reg  [7:0]  rx_buf_r [0:15];
	reg  [15:0] rx_msk_r;
	reg  [4:0]  rx_cnt_r;
	reg  [3:0]  rx_rd_r;
	reg  [10:0] rx_idx_r;
	reg  [10:0] rx_didx_r;
	reg  [10:0] rx_len_r;
	reg  [1:0]  rx_ht_r;
	reg         rx_ctl_r;
	reg         rx_bh_r;
	reg         rx_b8_r;
	reg         rx_b32_r;
	reg  [7:0]  rx_c8_r;
	reg  [31:0] rx_c32_r;
	wire [7:0]  rx_s8;
	wire [31:0] rx_s32;

	wire        rx_acc = rx_phy_valid & (rx_st_r == FILL);
	wire [10:0] rx_i   = rx_phy_first ? 11'h000 : rx_idx_r;
	wire [10:0] rx_l   = rx_phy_first ? rx_len : rx_len_r;
	wire [1:0]  rx_h   = rx_phy_first ? rx_phy_data[`MCX_HT_MSB:`MCX_HT_LSB] : rx_ht_r;
	wire        rx_me  = enc_on & (rx_h == `MCX_HT_GEN) & ~rx_ctl_r
		& (rx_i >= `MCX_ENC_START);
	wire        rx_end = (rx_cnt_r == 5'd15) | (rx_i == rx_l - 11'h001);

	// Checks run on the plaintext as it drains
	wire [7:0]  rx_b   = rx_buf_r[rx_rd_r];
	wire [10:0] rx_d   = rx_didx_r;
	wire        rx_a8  = crc_on & (rx_ht_r == `MCX_HT_GEN | rx_ht_r == `MCX_HT_PRO);
	wire        rx_a32 = crc_on & (rx_ht_r == `MCX_HT_GEN | rx_ht_r == `MCX_HT_BCN);
	wire [10:0] rx_p8  = (rx_ht_r == `MCX_HT_GEN) ? `MCX_POS_HCS : `MCX_POS_PRO;
	wire        rx_tl  = rx_d >= rx_len_r - `MCX_TAIL;
	wire [7:0]  rx_k8  = (rx_d == 11'h000) ? `MCX_C8_INIT : rx_c8_r;
	wire [31:0] rx_k32 = (rx_d != 11'h000) ? rx_c32_r
		: (rx_ht_r == `MCX_HT_GEN) ? seed_r : `MCX_C32_INIT;
	wire        rx_m8  = rx_a8 & (rx_d == rx_p8) & (rx_b != rx_k8);
	wire        rx_m32 = rx_a32 & rx_tl & (rx_b != rx_k32[31:24]);
	wire        rx_dl  = (rx_st_r == DRN) & (rx_d == rx_len_r - 11'h001);
	wire        rx_bh  = rx_bh_r | (rx_m8 & rx_ht_r == `MCX_HT_GEN);
	wire        rx_b8  = rx_b8_r | (rx_m8 & rx_ht_r == `MCX_HT_PRO);
	wire        rx_b32 = rx_b32_r | rx_m32;
	// A bad header CRC only drops the frame: no flag, no count
	assign rx_ev32 = rx_dl & rx_b32 & ~rx_bh;
	assign rx_ev8  = rx_dl & rx_b8;

	mcx_crc_step #(.W(8), .POLY(`MCX_C8_POLY)) u_rx8 (
		.crc_in  (rx_k8),
		.byte_in (rx_b),
		.crc_out (rx_s8)
	);

	mcx_crc_step #(.W(32), .POLY(`MCX_C32_POLY)) u_rx32 (
		.crc_in  (rx_k32),
		.byte_in (rx_b),
		.crc_out (rx_s32)
	);

	always @(posedge clk) begin
		if (sys_rst) begin
			rx_st_r <= FILL; rx_dma_valid <= 1'b0; rx_dma_data <= 8'h00;
			rx_dma_last <= 1'b0; rx_drop <= 1'b0; rx_msk_r <= 16'h0;
			rx_cnt_r <= 5'd0; rx_rd_r <= 4'h0; rx_idx_r <= 11'h0;
			rx_didx_r <= 11'h0; rx_len_r <= 11'h0; rx_ht_r <= 2'h0;
			rx_ctl_r <= 1'b0; rx_bh_r <= 1'b0; rx_b8_r <= 1'b0;
			rx_b32_r <= 1'b0; rx_c8_r <= 8'h00; rx_c32_r <= 32'h0;
			rx_blk_r <= 7'h0; rx_iss_r <= 1'b0;
		end else begin
			rx_dma_valid <= 1'b0;
			rx_dma_last  <= 1'b0;
			rx_drop      <= 1'b0;
			case (rx_st_r)
				FILL: begin
					if (rx_acc) begin
						rx_buf_r[rx_cnt_r[3:0]] <= rx_phy_data;
						rx_msk_r[rx_cnt_r[3:0]] <= rx_me;
						rx_cnt_r <= rx_cnt_r + 5'd1;
						rx_idx_r <= rx_i + 11'h001;
						rx_len_r <= rx_l;
						rx_ht_r  <= rx_h;
						if (rx_phy_first) begin
							rx_blk_r  <= 7'h0;
							rx_didx_r <= 11'h000;
							rx_ctl_r  <= 1'b0;
						end else if (rx_i == `MCX_POS_CTL) begin
							rx_ctl_r <= rx_phy_data[`MCX_CTL_BIT];
						end
						if (rx_end) rx_st_r <= (|rx_msk_r | rx_me) ? KS : DRN;
					end
				end
				KS: begin
					if (g_rx) rx_iss_r <= 1'b1;
					if (c_done && own_r == OWN_RX) begin
						for (j = 0; j < 16; j = j + 1) begin
							if (rx_msk_r[j]) rx_buf_r[j] <= rx_buf_r[j] ^ c_dout[(15-j)*8 +: 8];
						end
						rx_iss_r <= 1'b0;
						rx_st_r  <= DRN;
					end
				end
				DRN: begin
					rx_dma_valid <= 1'b1;
					rx_dma_data  <= rx_b;
					rx_rd_r      <= rx_rd_r + 4'h1;
					rx_didx_r    <= rx_d + 11'h001;
					rx_c8_r      <= (rx_a8 && rx_d < rx_p8) ? rx_s8 : rx_k8;
					rx_c32_r     <= (rx_a32 && rx_tl) ? {rx_k32[23:0], 8'h00}
						: rx_a32 ? rx_s32 : rx_k32;
					rx_bh_r      <= rx_bh & ~rx_dl;
					rx_b8_r      <= rx_b8 & ~rx_dl;
					rx_b32_r     <= rx_b32 & ~rx_dl;
					if (rx_dl) begin
						rx_dma_last <= 1'b1;
						rx_drop     <= rx_bh | rx_b8 | rx_b32;
					end
					if ({1'b0, rx_rd_r} == rx_cnt_r - 5'd1) begin
						rx_cnt_r <= 5'd0;
						rx_rd_r  <= 4'h0;
						rx_msk_r <= 16'h0;
						rx_blk_r <= rx_blk_r + 7'h01;
						rx_st_r  <= FILL;
					end
				end
				default: rx_st_r <= FILL;
			endcase
		end
	end
endmodule // mcx_mac_coproc

// ==== dv/mcx_mac_coproc_assertions.sv ====
// Port assertions for the MAC coprocessor
module mcx_coproc_chk (
	input logic        clk,
	input logic        sys_rst,
	input logic [15:0] reg_addr,
	input logic [7:0]  reg_wdata,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [7:0]  reg_rdata,
	input logic        tx_in_valid,
	input logic        tx_in_first,
	input logic        tx_dma_req,
	input logic        tx_phy_valid,
	input logic        tx_phy_last,
	input logic        rx_dma_valid,
	input logic        rx_dma_last,
	input logic        rx_drop
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;
	logic [2:0] ctrl_r;
	wire        tk = tx_in_valid && tx_dma_req;
	// ----
	// Helpers
	// ----
	// Byte slot within a block, and a mirror of the control bits
	always @(posedge clk) begin
		if (sys_rst) begin
			cnt_r <= 4'h0;
			ctrl_r <= 3'h1;
		end else begin
			if (tk)
				cnt_r <= tx_in_first ? 4'h1 : cnt_r + 4'h1;
			if (reg_wr && reg_addr == 16'hFE70)
				ctrl_r <= reg_wdata[2:0];
		end
	end
	// ----
	// Checks
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_ctrl_mirror: assert property (reg_rd && reg_addr == 16'hFE70 |=> reg_rdata[2:0] == ctrl_r)
		else $error("control readback wrong");
	a_drop_last: assert property (rx_drop |-> rx_dma_last && rx_dma_valid)
		else $error("drop without last byte");
	a_drop_pulse: assert property (rx_drop |=> !rx_drop)
		else $error("drop held too long");
	a_tx_last: assert property (tx_phy_last |-> tx_phy_valid)
		else $error("last flag without byte");
	a_req_reset: assert property ($fell(sys_rst) |-> !tx_dma_req ##[1:3] tx_dma_req)
		else $error("refill request missing after reset");
	a_req_block: assert property (tk && !tx_in_first && cnt_r == 4'hF |=> !tx_dma_req)
		else $error("request kept past a full block");
	a_req_drain: assert property (tx_phy_valid && tx_dma_req |=> !tx_phy_valid)
		else $error("request while draining");
	a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
	c_drop: cover property (rx_drop);
	c_tx_end: cover property (tx_phy_last);
	c_block: cover property (tk && cnt_r == 4'hF);
endmodule // mcx_coproc_chk

bind mcx_mac_coproc mcx_coproc_chk u_chk (
	.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_in_valid(tx_in_valid),
	.tx_in_first(tx_in_first), .tx_dma_req(tx_dma_req), .tx_phy_valid(tx_phy_valid),
	.tx_phy_last(tx_phy_last), .rx_dma_valid(rx_dma_valid), .rx_dma_last(rx_dma_last),
	.rx_drop(rx_drop)
);

// ==== dv/mcx_far_model.sv ====
// Far side model: DMA transmit source and PHY receive source
module mcx_far_model (
	input  logic        clk,
	input  logic        tx_dma_req,
	output logic        tx_in_valid,
	output logic [7:0]  tx_in_data,
	output logic        tx_in_first,
	output logic [10:0] tx_len,
	output logic        rx_phy_valid,
	output logic [7:0]  rx_phy_data,
	output logic        rx_phy_first,
	output logic [10:0] rx_len
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [19:0] txq[$];
	logic [20:0] rxq[$];
	integer      seed = 32'hB41F1582;
	int          gap = 0;
	initial begin
		{tx_in_valid, tx_in_first, tx_len, tx_in_data} = 21'h000000;
		{rx_phy_valid, rx_phy_first, rx_len, rx_phy_data} = 21'h000000;
	end
	// An offered byte stays until taken; random stalls fall only between bytes
	always @(posedge clk) begin
		if (tx_in_valid && tx_dma_req)
			void'(txq.pop_front());
		if (!tx_in_valid || tx_dma_req) begin
			if (txq.size() > 0 && ($random(seed) & 3) != 0)
				{tx_in_valid, tx_in_first, tx_len, tx_in_data} <= {1'b1, txq[0]};
			else
				{tx_in_valid, tx_in_first, tx_in_data} <= {2'b00, ~tx_in_data};
		end
	end
	// Idle gap after each block lets the receive buffer drain
	always @(posedge clk) begin
		if (gap > 0 || rxq.size() == 0) begin
			gap <= (gap > 0) ? gap - 1 : 0;
			{rx_phy_valid, rx_phy_first, rx_phy_data} <= {2'b00, ~rx_phy_data};
		end else begin
			gap <= rxq[0][20] ? 40 : 0;
			{rx_phy_valid, rx_phy_first, rx_len, rx_phy_data} <= {1'b1, rxq[0][19:0]};
			void'(rxq.pop_front());
		end
	end
endmodule // mcx_far_model

// ==== dv/mcx_mac_coproc_tb.sv ====
// Self-checking bench for the MAC coprocessor
module mcx_mac_coproc_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, rdd = 1'b0;
	logic [7:0]  reg_rdata, tx_in_data, tx_phy_data, rx_phy_data, rx_dma_data;
	logic        tx_in_valid, tx_in_first, tx_dma_req, tx_phy_valid, tx_phy_last;
	logic        rx_phy_valid, rx_phy_first, rx_dma_valid, rx_dma_last, rx_drop;
	logic [10:0] tx_len, rx_len;
	logic [8:0]  txe[$];
	logic [9:0]  rxe[$];
	logic [7:0]  rge[$], subnetwork_address[6];
	integer      seed = 32'hB41F1582;
	int          n_fail = 0, tests_run = 0, cyc = 0, k;
	mcx_mac_coproc dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data), .tx_in_first(tx_in_first),
		.tx_len(tx_len), .tx_dma_req(tx_dma_req), .tx_phy_valid(tx_phy_valid),
		.tx_phy_data(tx_phy_data), .tx_phy_last(tx_phy_last), .rx_phy_valid(rx_phy_valid),
		.rx_phy_data(rx_phy_data), .rx_phy_first(rx_phy_first), .rx_len(rx_len),
		.rx_dma_valid(rx_dma_valid), .rx_dma_data(rx_dma_data), .rx_dma_last(rx_dma_last),
		.rx_drop(rx_drop));
	mcx_far_model far (.clk(clk), .tx_dma_req(tx_dma_req), .tx_in_valid(tx_in_valid),
		.tx_in_data(tx_in_data), .tx_in_first(tx_in_first), .tx_len(tx_len),
		.rx_phy_valid(rx_phy_valid), .rx_phy_data(rx_phy_data),
		.rx_phy_first(rx_phy_first), .rx_len(rx_len));
	initial forever #2.5 clk = ~clk;
	// ----
	// Helpers
	// ----
	function automatic logic [7:0] c8(logic [7:0] c, logic [7:0] b);
		c = c ^ b;
		for (int i = 0; i < 8; i++)
			c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		return c;
	endfunction
	function automatic logic [31:0] c32(logic [31:0] c, logic [7:0] b);
		c = c ^ {b, 24'h000000};
		for (int i = 0; i < 8; i++)
			c = c[31] ? {c[30:0], 1'b0} ^ 32'h04C11DB7 : {c[30:0], 1'b0};
		return c;
	endfunction
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] e);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		rge.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	// One frame on transmit or receive; bad flips one byte after the checks are built, except byte 2, flipped before the CRC32 is built
	task automatic mk(logic [1:0] ht, logic [10:0] n, bit on, int bad, bit rx);
		logic [7:0]  f[24];
		logic [7:0]  h;
		logic [31:0] c;
		for (int i = 0; i < n; i++)
			f[i] = $random(seed);
		f[0][5:4] = ht;
		for (int i = 0; i < n && !rx; i++)
			far.txq.push_back({i == 0, n, f[i]});
		h = 8'h00;
		c = 32'h00000000;
		for (int i = 0; i < 13; i++) begin
			h = c8(h, f[i]);
			if (on && i == 1 && ht == 2'h0)
				f[2] = h;
		end
		if (on && ht == 2'h1)
			f[13] = h;
		if (bad == 2)
			f[2] = ~f[2];
		for (int i = 0; i < 6 && ht == 2'h0; i++)
			c = c32(c, subnetwork_address[i]);
		for (int i = 0; i < n - 4; i++)
			c = c32(c, f[i]);
		for (int i = 0; i < 4 && on && !ht[0]; i++)
			f[n - 4 + i] = c[31 - 8 * i -: 8];
		if (bad > 2)
			f[bad] = ~f[bad];
		for (int i = 0; i < n; i++)
			if (rx) begin
				far.rxq.push_back({i % 16 == 15 || i == n - 1, i == 0, n, f[i]});
				rxe.push_back({on && bad >= 0 && i == n - 1, i == n - 1, f[i]});
			end else
				txe.push_back({i == n - 1, f[i]});
		while (txe.size() > 0 || rxe.size() > 0)
			@(posedge clk);
	endtask
	// ----
	// Monitor and sequence
	// ----
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rdd <= reg_rd;
		if (rdd)
			chk("reg_rdata", reg_rdata, rge.pop_front());
		if (tx_phy_valid)
			chk("tx_byte", {tx_phy_last, tx_phy_data}, txe.pop_front());
		if (rx_dma_valid)
			chk("rx_byte", {rx_drop, rx_dma_last, rx_dma_data}, rxe.pop_front());
		if (cyc == 30000) begin
			n_fail++;
			test_done;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rd(16'hFE70, 8'h01);
		rd(16'hFE50, 8'h00);
		for (k = 0; k < 6; k++) begin
			subnetwork_address[k] = $random(seed);
			wr(16'hFE62 + k[15:0], subnetwork_address[k]);
		end
		rd(16'hFE67, subnetwork_address[5]);
		repeat (8) @(posedge clk);
		for (k = 0; k < 4; k++)
			mk(k[1:0], 11'h014, 1, -1, 0);
		mk(2'h0, 11'h018, 1, -1, 1);
		mk(2'h0, 11'h018, 1, 2, 1);
		mk(2'h0, 11'h018, 1, 23, 1);
		mk(2'h1, 11'h014, 1, 13, 1);
		mk(2'h2, 11'h014, 1, -1, 1);
		mk(2'h2, 11'h014, 1, 19, 1);
		rd(16'hFEBB, 8'h02);
		rd(16'hFEBA, 8'h00);
		rd(16'hFEBD, 8'h01);
		rd(16'hFE71, 8'h03);
		wr(16'hFE71, 8'h03);
		wr(16'hFEBB, 8'h00);
		rd(16'hFE71, 8'h00);
		rd(16'hFEBB, 8'h00);
		for (k = 0; k < 2; k++) begin
			wr(16'hFE70, k[0] ? 8'h05 : 8'h00);
			mk(2'h2, 11'h014, 0, -1, 0);
			mk(2'h2, 11'h014, 0, -1, 1);
		end
		rd(16'hFEBB, 8'h00);
		test_done;
	end
endmodule // mcx_mac_coproc_tb
